// *** eeprom_map.svh ***
// Constants of the serial EEPROM core: address map, fields, reset values, timing.
// How it works
// - Byte write: address, two address bytes, data acknowledged.
// - STOP after accepted write starts programming.
// - No address acknowledge while programming runs.
// - Array is 256 pages of 64 bytes.
// - High eight bits page, low six bits byte.
// - Page write wraps inside the page.
// - Top address bit picks register; next ignored.
// - Protection register: enable, two selects, lock.
// - Enable bit off leaves whole array writable.
// - Select pair picks protected upper range.
// - Lock bit freezes protection register forever.
// - Protected data byte is refused and dropped.
// - Register write needs exactly one data byte.
// - Read address returns byte at counter.
// - Random read loads counter from header address.
// - Sequential read wraps at end of array.
// - Register read repeats register while acknowledged.
// - Delivered state: array FFh, register 00h.
// - Target address is 1010 001 plus direction.
// - Receiver acknowledges by pulling data low.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define DEV_ADDR 7'h51
`define ARRAY_BYTES 16384
`define PAGE_BYTES 64
`define ADDR_W 14
`define REGION_BIT 7
`define IGNORED_BIT 6
`define PROT_EN_BIT 3
`define PROT_BSHI_BIT 2
`define PROT_BSLO_BIT 1
`define PROT_LOCK_BIT 0
`define PROT_RESET 4'h0
`define ERASED_BYTE 8'hff
`define ACK_SLOT 4'h8
`define LAST_BIT 4'h7
`define CLOCK_MHZ 200
`define WRITE_TIME_US 5000
`define WRITE_CYCLES (`WRITE_TIME_US * `CLOCK_MHZ)
`define BUSY_CNT_W 20
`endif

// *** eeprom_pkg.sv ***
// Types shared by the serial EEPROM core.
`default_nettype none
package eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_AHI = 3'h3,
        ST_ALO = 3'h2,
        ST_WDATA = 3'h6,
        ST_RDATA = 3'h5,
        ST_DROP = 3'h4
    } core_st_t;

    typedef struct packed {
        core_st_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [13:0] addr;
        logic region;
        logic ack;
        logic sda_oe;
        logic [1:0] wcnt;
        logic [3:0] prot;
        logic [3:0] prot_new;
        logic busy;
        logic [19:0] busy_cnt;
        logic prog_region;
        logic [7:0] prog_page;
        logic scl_prev;
        logic sda_prev;
        logic tgl_prev;
        logic tgl_old;
    } core_t;
endpackage
`default_nettype wire

// *** eeprom_sync.sv ***
// Two-stage synchroniser for the pins and the link-domain event.
`timescale 1ns/1ps
`default_nettype none
module eeprom_sync (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);
    logic [3:0] meta_q;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= 4'h0;
            sync_out <= 4'h0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** eeprom_link_rx.sv ***
// Serial clock domain: samples the data line on each rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_rx (
    input wire logic scl_in,
    input wire logic resetn_in,
    input wire logic sda_in,
    output logic bit_out,
    output logic toggle_out
);
    // The bit and the toggle change on the same edge, so the core reads the
    // bit one clock after the toggle has crossed, when the bit has settled.
    always_ff @(posedge scl_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_out <= 1'b0;
            toggle_out <= 1'b0;
        end else begin
            bit_out <= sda_in;
            toggle_out <= ~toggle_out;
        end
    end
endmodule
`default_nettype wire

// *** serial_eeprom_rw_protect.sv ***
// Serial EEPROM core: target protocol, array, page buffer, write protection.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"
module serial_eeprom_rw_protect #(
    parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic busy_out
);
    import eeprom_pkg::*;

    core_t q;
    core_t d;
    logic lk_bit;
    logic lk_tgl;
    logic [3:0] sync_w;
    logic s_scl;
    logic s_sda;
    logic s_tgl;
    logic s_bit;
    logic bit_ev;
    logic fall_ev;
    logic start_ev;
    logic stop_ev;
    logic rx_byte;
    logic [7:0] rx_data;
    logic [13:0] addr_page_inc;
    logic commit_arr;
    logic buf_we;
    logic buf_clr;
    logic load_tx;
    logic [7:0] mem_q [0:`ARRAY_BYTES-1];
    logic [7:0] pbuf_q [0:`PAGE_BYTES-1];
    logic [`PAGE_BYTES-1:0] pval_q;

    ////////////////////////////////////////////////////////////////////////
    // True when a write to addr falls in the range the register guards.
    function automatic logic is_prot(input logic [13:0] a, input logic [3:0] w);
        logic hit;
        hit = 1'b0;
        case ({w[`PROT_BSHI_BIT], w[`PROT_BSLO_BIT]})
            2'h0: hit = (a[13:12] == 2'h3);
            2'h1: hit = a[13];
            2'h2: hit = (a[13:12] != 2'h0);
            default: hit = 1'b1;
        endcase
        return w[`PROT_EN_BIT] & hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    eeprom_link_rx u_link (
        .scl_in(scl_in),
        .resetn_in(resetn_in),
        .sda_in(sda_in),
        .bit_out(lk_bit),
        .toggle_out(lk_tgl)
    );

    eeprom_sync u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in({scl_in, sda_in, lk_tgl, lk_bit}),
        .sync_out(sync_w)
    );

    assign s_scl = sync_w[3];
    assign s_sda = sync_w[2];
    assign s_tgl = sync_w[1];
    assign s_bit = sync_w[0];
    // One extra stage on the toggle, so a bit caught late by its synchroniser
    // is never taken together with a toggle that resolved early.
    assign bit_ev = q.tgl_prev != q.tgl_old;
    assign fall_ev = q.scl_prev & ~s_scl;
    assign start_ev = q.scl_prev & s_scl & q.sda_prev & ~s_sda;
    assign stop_ev = q.scl_prev & s_scl & ~q.sda_prev & s_sda;
    assign rx_data = {q.shreg[6:0], s_bit};
    assign rx_byte = bit_ev && q.bitcnt == `LAST_BIT && q.st != ST_IDLE
        && q.st != ST_DROP && q.st != ST_RDATA;
    assign addr_page_inc = {q.addr[13:6], 6'(q.addr[5:0] + 6'h1)};
    assign commit_arr = q.busy && q.busy_cnt == 20'h1 && !q.prog_region;
    assign sda_oe_out = q.sda_oe;
    assign busy_out = q.busy;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        buf_we = 1'b0;
        buf_clr = 1'b0;
        load_tx = 1'b0;
        d.scl_prev = s_scl;
        d.sda_prev = s_sda;
        d.tgl_prev = s_tgl;
        d.tgl_old = q.tgl_prev;
        // Contents change only when the full programming time has run.
        if (q.busy) begin
            d.busy_cnt = q.busy_cnt - 20'h1;
            if (q.busy_cnt == 20'h1) begin
                d.busy = 1'b0;
                if (q.prog_region) begin
                    d.prot = q.prot_new;
                end
            end
        end
        if (bit_ev && q.st != ST_IDLE && q.st != ST_DROP) begin
            if (q.bitcnt == `ACK_SLOT) begin
                d.bitcnt = 4'h0;
                d.ack = 1'b0;
                // After our own acknowledge there is no master answer.
                if (q.st == ST_RDATA && !q.ack) begin
                    if (s_bit) begin
                        d.st = ST_DROP;
                    end else begin
                        load_tx = 1'b1;
                    end
                end
            end else begin
                d.bitcnt = q.bitcnt + 4'h1;
                d.shreg = rx_data;
            end
        end
        if (rx_byte) begin
            case (q.st)
                ST_DEV: begin
                    if (rx_data[7:1] == `DEV_ADDR && !q.busy) begin
                        d.ack = 1'b1;
                        if (rx_data[0]) begin
                            d.st = ST_RDATA;
                            load_tx = 1'b1;
                        end else begin
                            d.st = ST_AHI;
                        end
                    end else begin
                        d.st = ST_DROP;
                    end
                end
                ST_AHI: begin
                    d.ack = 1'b1;
                    d.region = rx_data[`REGION_BIT];
                    d.addr = {rx_data[5:0], q.addr[7:0]};
                    d.st = ST_ALO;
                end
                ST_ALO: begin
                    d.ack = 1'b1;
                    d.addr = {q.addr[13:8], rx_data};
                    d.wcnt = 2'h0;
                    buf_clr = 1'b1;
                    d.st = ST_WDATA;
                end
                ST_WDATA: begin
                    if (q.region) begin
                        if (q.prot[`PROT_LOCK_BIT]) begin
                            d.st = ST_DROP;
                        end else begin
                            d.ack = 1'b1;
                            d.prot_new = rx_data[3:0];
                            d.wcnt = (q.wcnt == 2'h0) ? 2'h1 : 2'h2;
                        end
                    end else if (is_prot(q.addr, q.prot)) begin
                        d.st = ST_DROP;
                    end else begin
                        d.ack = 1'b1;
                        buf_we = 1'b1;
                        d.addr = addr_page_inc;
                        d.wcnt = (q.wcnt == 2'h0) ? 2'h1 : 2'h2;
                    end
                end
                default: d.st = ST_DROP;
            endcase
        end
        if (load_tx) begin
            if (q.region) begin
                d.tx = {4'h0, q.prot};
            end else begin
                d.tx = mem_q[q.addr];
                d.addr = q.addr + 14'h1;
            end
        end
        // The line driver changes on a falling serial clock edge, or is released at START and STOP.
        if (fall_ev) begin
            if (d.ack && d.bitcnt == `ACK_SLOT) begin
                d.sda_oe = 1'b1;
            end else if (d.st == ST_RDATA && !d.ack && d.bitcnt < `ACK_SLOT) begin
                d.sda_oe = ~d.tx[~d.bitcnt[2:0]];
            end else begin
                d.sda_oe = 1'b0;
            end
        end
        if (stop_ev) begin
            if (q.wcnt != 2'h0 && (!q.region || q.wcnt == 2'h1)) begin
                d.busy = 1'b1;
                d.busy_cnt = 20'(WRITE_CYCLES);
                d.prog_region = q.region;
                d.prog_page = q.addr[13:6];
            end
            d.st = ST_IDLE;
            d.bitcnt = 4'h0;
            d.ack = 1'b0;
            d.sda_oe = 1'b0;
            d.wcnt = 2'h0;
        end
        // A repeated START throws away any write not closed by STOP.
        if (start_ev) begin
            d.st = ST_DEV;
            d.bitcnt = 4'h0;
            d.ack = 1'b0;
            d.sda_oe = 1'b0;
            d.wcnt = 2'h0;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.prot <= `PROT_RESET;
            sda_out <= 1'b0;
        end else begin
            q <= d;
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The page buffer gathers a whole write so that the array only sees it
    // after the programming time, never while a poll can still read it.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pval_q <= '0;
            for (int i = 0; i < `PAGE_BYTES; i++) begin
                pbuf_q[i] <= `ERASED_BYTE;
            end
        end else if (buf_clr) begin
            pval_q <= '0;
        end else if (buf_we) begin
            pbuf_q[q.addr[5:0]] <= rx_data;
            pval_q[q.addr[5:0]] <= 1'b1;
        end
    end

    // Reset stands in for the erased delivered state of the array.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `ARRAY_BYTES; i++) begin
                mem_q[i] <= `ERASED_BYTE;
            end
        end else if (commit_arr) begin
            for (int i = 0; i < `PAGE_BYTES; i++) begin
                if (pval_q[i]) begin
                    mem_q[{q.prog_page, 6'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    property p_busy_start;
        stop_ev && q.wcnt == 2'h1 |=> q.busy && q.busy_cnt == 20'(WRITE_CYCLES);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("no write cycle on stop");

    property p_busy_nack;
        rx_byte && q.st == ST_DEV && q.busy |=> q.st == ST_DROP && !q.ack;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

    property p_busy_count;
        q.busy && q.busy_cnt > 20'h1 |=> q.busy && q.busy_cnt == $past(q.busy_cnt) - 20'h1;
    endproperty
    a_busy_count: assert property (p_busy_count) else $error("busy count broken");

    property p_page_wrap;
        rx_byte && q.st == ST_WDATA && !q.region && !is_prot(q.addr, q.prot)
            |=> q.addr == $past(addr_page_inc) && q.ack;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address wrong");

    property p_prot_nack;
        rx_byte && q.st == ST_WDATA && !q.region && is_prot(q.addr, q.prot)
            |=> q.st == ST_DROP && !q.ack ##1 !q.sda_oe;
    endproperty
    a_prot_nack: assert property (p_prot_nack) else $error("protected byte acked");

    property p_lock;
        q.prot[`PROT_LOCK_BIT] |=> q.prot == $past(q.prot);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");

    property p_prot_read;
        load_tx && q.region |=> q.tx == {4'h0, q.prot} && $stable(q.addr);
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("register read wrong");

    property p_seq_wrap;
        load_tx && !q.region |=> q.addr == $past(q.addr) + 14'h1;
    endproperty
    a_seq_wrap: assert property (p_seq_wrap) else $error("read counter wrong");

    property p_ack_drive;
        fall_ev && q.ack && q.bitcnt == `ACK_SLOT && !bit_ev && !stop_ev && !start_ev
            |=> q.sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

    property p_dev_match;
        rx_byte && q.st == ST_DEV && !q.busy && rx_data[7:1] == `DEV_ADDR
            |=> q.ack && (q.st == ST_AHI || q.st == ST_RDATA);
    endproperty
    a_dev_match: assert property (p_dev_match) else $error("own address refused");
endmodule
`default_nettype wire

// *** i2c_master_model.sv ***
// Behavioural bus master that drives the serial clock and the start and stop conditions.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One bit from a falling clock edge; the line is sampled late in the high phase because
    // the device only answers a few core cycles after the fall.
    // Line changes are non-blocking, so one that lands on a core clock edge
    // is always seen by the synchronisers after that edge.
    task automatic bit_slot(input logic b, output logic r);
        #4 sda_low_out <= ~b;
        #12 scl_out <= 1'b1;
        #14 r = sda_in;
        #2 scl_out <= 1'b0;
    endtask
    task automatic start_cond();
        #4 sda_low_out <= 1'b0;
        #12 scl_out <= 1'b1;
        #16 sda_low_out <= 1'b1;
        #16 scl_out <= 1'b0;
    endtask
    // The clock is left high, so it stands still between frames.
    task automatic stop_cond();
        #4 sda_low_out <= 1'b1;
        #12 scl_out <= 1'b1;
        #16 sda_low_out <= 1'b0;
        #32;
    endtask
    task automatic write_byte(input logic [7:0] d, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r);
        end
        bit_slot(1'b1, r);
        acked = ~r;
    endtask
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_slot(1'b1, r);
            d = {d[6:0], r};
        end
        bit_slot(last, r);
    endtask
endmodule
`default_nettype wire

// *** serial_eeprom_rw_protect_bench.sv ***
// Self-checking bench for the serial EEPROM core driven by a bus master model.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_rw_protect_bench;
    localparam int WP = 400;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic sda_out;
    logic busy;
    wire logic sda_wire = ~(m_low | (sda_oe & ~sda_out));
    int failures = 0;
    int num_checks = 0;
    int busy_len = 0;
    int busy_last = 0;
    logic [7:0] rb [4];
    // With full protection the probe sits at an untouched byte, clear of the
    // register region that 0000h minus one would reach.
    logic [15:0] lim [4] = '{16'h3000, 16'h2000, 16'h1000, 16'h0400};

    always #2.5 clock_in = ~clock_in;

    serial_eeprom_rw_protect #(.WRITE_CYCLES(WP)) uut (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe),
        .busy_out(busy)
    );
    i2c_master_model m (
        .sda_in(sda_wire),
        .scl_out(scl),
        .sda_low_out(m_low)
    );

    always @(posedge clock_in) begin
        if (busy) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            busy_last <= busy_len;
            busy_len <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask
    // Re-addresses the device until it answers; the bound stands in for a hang.
    task automatic poll(output int nacks);
        logic ack;
        nacks = 0;
        for (int i = 0; i < 60; i++) begin
            m.start_cond();
            m.write_byte(8'ha2, ack);
            m.stop_cond();
            if (ack) begin
                return;
            end
            nacks++;
        end
        cmp_flag(1'b0, 1'b1, "device stays busy");
        end_of_test();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d0, input int n,
                      input logic dack, input logic cyc);
        logic ack;
        int nk;
        m.start_cond();
        m.write_byte(8'ha2, ack);
        cmp_flag(ack, 1'b1, "device address ack");
        m.write_byte(a[15:8], ack);
        cmp_flag(ack, 1'b1, "high address ack");
        m.write_byte(a[7:0], ack);
        cmp_flag(ack, 1'b1, "low address ack");
        for (int i = 0; i < n; i++) begin
            m.write_byte(d0 + i[7:0], ack);
            if (i == 0) cmp_flag(ack, dack, "data ack");
        end
        m.stop_cond();
        repeat (2) @(posedge clock_in);
        cmp_flag(busy, cyc, "programming started");
        if (cyc) begin
            poll(nk);
            cmp_flag(nk > 0, 1'b1, "address refused while busy");
            cmp_flag(busy_last == WP, 1'b1, "busy length");
        end
    endtask
    task automatic rd(input logic [15:0] a, input int n, input logic rnd);
        logic ack;
        if (rnd) begin
            m.start_cond();
            m.write_byte(8'ha2, ack);
            m.write_byte(a[15:8], ack);
            m.write_byte(a[7:0], ack);
        end
        m.start_cond();
        m.write_byte(8'ha3, ack);
        cmp_flag(ack, 1'b1, "read address ack");
        for (int i = 0; i < n; i++) begin
            m.read_byte(i == n - 1, rb[i]);
        end
        m.stop_cond();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_delivered();
        rd(16'h0000, 1, 1'b1);
        cmp_byte(rb[0], 8'hff, "erased array");
        rd(16'h8000, 2, 1'b1);
        cmp_byte(rb[0], 8'h00, "register delivered");
        cmp_byte(rb[1], 8'h00, "register repeated");
        $display("delivered state test done");
    endtask
    task automatic test_write_read();
        wr(16'h4000, 8'h5a, 2, 1'b1, 1'b1);
        rd(16'h3fff, 2, 1'b1);
        cmp_byte(rb[0], 8'hff, "last array byte");
        cmp_byte(rb[1], 8'h5a, "wrapped to first byte");
        rd(16'h0000, 1, 1'b0);
        cmp_byte(rb[0], 8'h5b, "immediate read");
        wr(16'h00be, 8'h00, 65, 1'b1, 1'b1);
        rd(16'h00be, 3, 1'b1);
        cmp_byte(rb[0], 8'h40, "overwritten first byte");
        cmp_byte(rb[1], 8'h01, "page last byte");
        cmp_byte(rb[2], 8'hff, "next page untouched");
        rd(16'h0080, 1, 1'b1);
        cmp_byte(rb[0], 8'h02, "page wrapped");
        $display("write and read test done");
    endtask
    task automatic test_protect();
        for (int c = 0; c < 4; c++) begin
            wr(16'h8000, {4'hf, 1'b1, c[1:0], 1'b0}, 1, 1'b1, 1'b1);
            rd(16'h8000, 1, 1'b1);
            cmp_byte(rb[0], {5'h01, c[1:0], 1'b0}, "register value");
            wr(lim[c], 8'h11, 1, 1'b0, 1'b0);
            if (c < 3) begin
                wr(lim[c] - 16'h1, 8'h20 + c[7:0], 1, 1'b1, 1'b1);
            end
            rd(lim[c] - 16'h1, 2, 1'b1);
            cmp_byte(rb[1], 8'hff, "protected byte kept");
            if (c < 3) cmp_byte(rb[0], 8'h20 + c[7:0], "writable byte");
        end
        wr(16'h8000, 8'h06, 1, 1'b1, 1'b1);
        wr(16'h3000, 8'h77, 1, 1'b1, 1'b1);
        rd(16'h3000, 1, 1'b1);
        cmp_byte(rb[0], 8'h77, "unprotected write");
        wr(16'h8000, 8'h0e, 2, 1'b1, 1'b0);
        rd(16'h8000, 1, 1'b1);
        cmp_byte(rb[0], 8'h06, "register after two bytes");
        $display("protection test done");
    endtask
    task automatic test_abort();
        logic ack;
        logic [7:0] bad [3] = '{8'ha0, 8'h22, 8'ha4};
        for (int i = 0; i < 3; i++) begin
            m.start_cond();
            m.write_byte(bad[i], ack);
            m.stop_cond();
            cmp_flag(ack, 1'b0, "foreign address");
        end
        m.start_cond();
        m.write_byte(8'ha2, ack);
        m.write_byte(8'h00, ack);
        m.write_byte(8'h10, ack);
        m.write_byte(8'h33, ack);
        rd(16'h0000, 1, 1'b0);
        repeat (2) @(posedge clock_in);
        cmp_flag(busy, 1'b0, "aborted write");
        rd(16'h0010, 1, 1'b1);
        cmp_byte(rb[0], 8'hff, "aborted data dropped");
        $display("abort test done");
    endtask
    task automatic test_lock();
        wr(16'h8000, 8'h0f, 1, 1'b1, 1'b1);
        wr(16'h8000, 8'h00, 1, 1'b0, 1'b0);
        rd(16'h8000, 1, 1'b1);
        cmp_byte(rb[0], 8'h0f, "locked register");
        $display("lock test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        cmp_flag(1'b0, 1'b1, "run timed out");
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clock_in);
        cmp_flag(sda_oe, 1'b0, "line released in reset");
        cmp_flag(busy, 1'b0, "idle in reset");
        resetn_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        // Offsets the link timing from the core clock edges.
        #1.3;
        test_delivered();
        test_write_read();
        test_protect();
        test_abort();
        test_lock();
        end_of_test();
    end
endmodule
`default_nettype wire
